// file: rtl/uart_lce_regs.svh
// Field codes, reset values and bit-period counts of the line-control extensions.
`ifndef UART_LCE_REGS_SVH
`define UART_LCE_REGS_SVH

// Codes of the parity mode field.
`define PAR_EVEN 3'h0
`define PAR_ODD 3'h1
`define PAR_SPACE 3'h2
`define PAR_MARK 3'h3
`define PAR_NONE 3'h4
`define PAR_NONE_ALT 3'h5
`define PAR_MULTIDROP_DATA 3'h6
`define PAR_MULTIDROP_ADDR 3'h7

// Operating mode code that selects hardware handshaking.
`define MODE_HANDSHAKE 4'h2

// Bits of one character: start, eight data bits and one stop bit, without parity.
`define CHAR_BITS_NOPAR 8'h0a
// Least idle time after a break, in bit periods.
`define BREAK_GAP_BITS 8'h0c
// High samples that end a received break, asynchronous and synchronous.
`define BRK_END_ASYNC 2'h2
`define BRK_END_SYNC 2'h1
// Reset values of the time-out counter and the bit counter.
`define TIMEOUT_RESET 16'h0000
`define COUNT_RESET 8'h00

`endif

// file: rtl/uart_lce_pkg.sv
// Types shared by the line-control extension files.
package uart_lce_pkg;

	// States of the transmit sequencer.
	typedef enum logic [2:0] {
		TX_IDLE = 3'h0,
		TX_START = 3'h1,
		TX_DATA = 3'h2,
		TX_PARITY = 3'h3,
		TX_STOP = 3'h4,
		TX_GUARD = 3'h5,
		TX_BREAK = 3'h6,
		TX_GAP = 3'h7
	} txState_e;

	typedef logic [7:0] char_t;

endpackage

// file: rtl/lce_fifo.sv
// Small first-in first-out buffer with valid and ready on both sides.
`timescale 1ns/100ps
module lce_fifo #(
	parameter int WIDTH = 8,
	parameter int DEPTH = 4
) (
	// Clock and reset.
	input wire logic mclk,
	input wire logic srst,
	// Filling side.
	input wire logic inValid,
	output logic inReady,
	input wire logic [WIDTH-1:0] inData,
	// Draining side.
	output logic outValid,
	input wire logic outReady,
	output logic [WIDTH-1:0] outData
);
	localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

	// Refuse depths that the pointer arithmetic cannot serve.
	generate
		if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0 || WIDTH < 1) begin : gBadParam
			$error("lce_fifo needs a power-of-two depth of at least two");
		end
	endgenerate

	logic [WIDTH-1:0] mem_r [DEPTH];
	logic [AW-1:0] wrPtr_r;
	logic [AW-1:0] rdPtr_r;
	logic [AW:0] count_r;
	logic push;
	logic pop;

	// Full and empty come straight from the occupancy count.
	assign inReady = (count_r < (AW+1)'(DEPTH));
	assign outValid = (count_r != '0);
	assign push = inValid && inReady;
	assign pop = outValid && outReady;
	assign outData = mem_r[rdPtr_r];

	// Storage is written only at the write pointer.
	always_ff @(posedge mclk) begin
		if (push) begin
			mem_r[wrPtr_r] <= inData;
		end
	end

	// Pointers and count move with accepted pushes and pops.
	always_ff @(posedge mclk) begin
		if (srst) begin
			wrPtr_r <= '0;
			rdPtr_r <= '0;
			count_r <= '0;
		end else begin
			if (push) begin
				wrPtr_r <= wrPtr_r + 1'b1;
			end
			if (pop) begin
				rdPtr_r <= rdPtr_r + 1'b1;
			end
			if (push && !pop) begin
				count_r <= count_r + 1'b1;
			end else if (pop && !push) begin
				count_r <= count_r - 1'b1;
			end
		end
	end

endmodule

// file: rtl/uart_line_control_extensions.sv
// Multidrop, timeguard, receive time-out, break and handshaking logic of a serial port.
//
// Operation
// RQ1: Parity codes six and seven select multidrop.
// RQ2: Multidrop sends data parity low, addresses high.
// RQ3: Multidrop receiver flags parity error on high parity.
// RQ4: Send-address command marks next written character.
// RQ5: Clear-status command clears the parity error flag.
// RQ6: Nonzero guard time adds idle bit periods.
// RQ7: Guard time delays holding-free and idle flags.
// RQ8: Zero time-out value keeps time-out flag low.
// RQ9: Time-out counter loads, decrements, reloads, flags zero.
// RQ10: Arm command freezes counter until first character.
// RQ11: Reload command restarts counting down at once.
// RQ12: Low stop bit sets framing error, clearable.
// RQ13: Break waits for current character, holds line low.
// RQ14: Repeated break starts ignored while break active.
// RQ15: Early break stop still completes one character.
// RQ16: Break commands need holding free; start clears flags.
// RQ17: Software never writes break start and stop together.
// RQ18: Stray stops ignored; writes during pending break dropped.
// RQ19: Line high twelve bits or guard after break.
// RQ20: All-zero character sets break seen, not framing.
// RQ21: High line after break sets break seen again.
// RQ22: Operating mode code two enables handshaking.
// RQ23: Handshake drives request high when reception impossible.
// RQ24: High clear-to-send stops transmitter after character.
// RQ25: Time-out flag holds until arm or reload.
`timescale 1ns/100ps
`include "uart_lce_regs.svh"
module uart_line_control_extensions #(
	parameter int RX_FIFO_DEPTH = 4
) (
	// Clock, reset and bit-rate strobes.
	input wire logic mclk,
	input wire logic srst,
	input wire logic bitTick,
	input wire logic sampleTick,
	// Configuration.
	input wire logic [2:0] parityModeField,
	input wire logic [3:0] operatingModeField,
	input wire logic syncMode,
	input wire logic [7:0] guardTimeField,
	input wire logic [15:0] timeoutValueField,
	// Command strobes.
	input wire logic sendAddressCmd,
	input wire logic clearStatusCmd,
	input wire logic armTimeoutCmd,
	input wire logic reloadTimeoutCmd,
	input wire logic breakStartCmd,
	input wire logic breakStopCmd,
	// Transmit holding register write.
	input wire logic holdingWrite,
	input wire logic [7:0] holdingData,
	// Status.
	output logic txHoldingFreeFlag,
	output logic txIdleFlag,
	output logic parityErrorFlag,
	output logic framingErrorFlag,
	output logic breakSeenFlag,
	output logic timeoutFlag,
	// Received character from the shifter.
	input wire logic rxCharDone,
	input wire logic [7:0] rxCharData,
	input wire logic rxParityBit,
	input wire logic rxStopBit,
	input wire logic rxEnable,
	input wire logic rxBufferFullStatus,
	// Received character stream.
	output logic rxOutValid,
	input wire logic rxOutReady,
	output logic [7:0] rxOutData,
	// Serial pins.
	output logic txd,
	input wire logic rxd,
	input wire logic cts,
	output logic rts
);
	// Refuse a receive buffer of fewer than two words; the buffer module refuses other bad depths.
	generate
		if (RX_FIFO_DEPTH < 2) begin : gBadDepth
			$error("receive buffer needs at least two words");
		end
	endgenerate

	// Parity value that the configured mode gives for a character.
	function automatic logic parityOf(input logic [2:0] mode, input logic [7:0] data,
			input logic addr);
		unique case (mode)
			`PAR_EVEN: parityOf = ^data;
			`PAR_ODD: parityOf = ~^data;
			`PAR_SPACE: parityOf = 1'b0;
			`PAR_MARK: parityOf = 1'b1;
			`PAR_MULTIDROP_DATA, `PAR_MULTIDROP_ADDR: parityOf = addr;
			default: parityOf = 1'b0;
		endcase
	endfunction

	// True when the mode carries a parity position.
	function automatic logic hasParity(input logic [2:0] mode);
		hasParity = (mode != `PAR_NONE) && (mode != `PAR_NONE_ALT);
	endfunction

	uart_lce_pkg::txState_e txState_r;
	uart_lce_pkg::txState_e txState_nxt;
	uart_lce_pkg::txState_e launchState;
	uart_lce_pkg::char_t shift_r;
	uart_lce_pkg::char_t holdData_r;
	logic [7:0] bitCnt_r;
	logic [7:0] charBits;
	logic [7:0] gapBits;
	logic parBit_r;
	logic holdAddr_r;
	logic holdFull_r;
	logic addrPend_r;
	logic brkPend_r;
	logic brkStopReq_r;
	logic brkMinDone_r;
	logic multidrop;
	logic handshake;
	logic ctsBlock;
	logic launch;
	logic holdAccept;
	logic brkStartOk;
	logic brkStopOk;
	logic rxBreak;
	logic rxInBreak_r;
	logic [1:0] hiCnt_r;
	logic brkEnd;
	logic endSample;
	logic [15:0] toCnt_r;
	logic toRun_r;
	logic toWait_r;
	logic fifoReady;

	assign multidrop = (parityModeField == `PAR_MULTIDROP_DATA) ||
		(parityModeField == `PAR_MULTIDROP_ADDR); // [RQ1]
	assign handshake = (operatingModeField == `MODE_HANDSHAKE); // [RQ22]
	assign ctsBlock = handshake && cts; // [RQ24]
	assign charBits = `CHAR_BITS_NOPAR + {7'h00, hasParity(parityModeField)};
	assign gapBits = (guardTimeField > `BREAK_GAP_BITS) ? guardTimeField : `BREAK_GAP_BITS; // [RQ19]

	// Status flags of the transmitter follow the holding register and the sequencer.
	assign txHoldingFreeFlag = !holdFull_r && !brkPend_r && (txState_r != uart_lce_pkg::TX_GAP);
	assign txIdleFlag = (txState_r == uart_lce_pkg::TX_IDLE) && !holdFull_r && !brkPend_r; // [RQ7]
	assign holdAccept = holdingWrite && !holdFull_r && !brkPend_r; // [RQ18]
	assign brkStartOk = breakStartCmd && txHoldingFreeFlag && (txState_r != uart_lce_pkg::TX_BREAK); // [RQ14] [RQ16]
	assign brkStopOk = breakStopCmd && txHoldingFreeFlag && (txState_r == uart_lce_pkg::TX_BREAK); // [RQ16] [RQ18]

	// What follows the end of a character: a pending break first, then a waiting character.
	always_comb begin
		if (brkPend_r) begin
			launchState = uart_lce_pkg::TX_BREAK; // [RQ13]
		end else if (holdFull_r && !ctsBlock) begin
			launchState = uart_lce_pkg::TX_START; // [RQ24]
		end else begin
			launchState = uart_lce_pkg::TX_IDLE;
		end
	end

	// Next state of the transmit sequencer; every step waits for a bit period.
	always_comb begin
		txState_nxt = txState_r;
		if (bitTick) begin
			unique case (txState_r)
				uart_lce_pkg::TX_IDLE: txState_nxt = launchState;
				uart_lce_pkg::TX_START: txState_nxt = uart_lce_pkg::TX_DATA;
				uart_lce_pkg::TX_DATA: begin
					if (bitCnt_r == 8'h07) begin
						txState_nxt = hasParity(parityModeField) ? uart_lce_pkg::TX_PARITY :
							uart_lce_pkg::TX_STOP;
					end
				end
				uart_lce_pkg::TX_PARITY: txState_nxt = uart_lce_pkg::TX_STOP;
				uart_lce_pkg::TX_STOP: begin
					txState_nxt = (guardTimeField != 8'h00) ? uart_lce_pkg::TX_GUARD : launchState; // [RQ6]
				end
				uart_lce_pkg::TX_GUARD: begin
					if (bitCnt_r + 8'h01 >= guardTimeField) begin
						txState_nxt = launchState; // [RQ6]
					end
				end
				uart_lce_pkg::TX_BREAK: begin
					if ((brkMinDone_r || bitCnt_r + 8'h01 >= charBits) && brkStopReq_r) begin
						txState_nxt = uart_lce_pkg::TX_GAP; // [RQ15]
					end
				end
				uart_lce_pkg::TX_GAP: begin
					if (bitCnt_r + 8'h01 >= gapBits) begin
						txState_nxt = launchState; // [RQ19]
					end
				end
			endcase
		end
	end

	assign launch = (txState_nxt == uart_lce_pkg::TX_START) && (txState_r != uart_lce_pkg::TX_START);

	// Sequencer state, bit counter and shifter.
	always_ff @(posedge mclk) begin
		if (srst) begin
			txState_r <= uart_lce_pkg::TX_IDLE;
			bitCnt_r <= `COUNT_RESET;
			shift_r <= 8'h00;
			parBit_r <= 1'b0;
			brkMinDone_r <= 1'b0;
		end else begin
			txState_r <= txState_nxt;
			if (launch) begin
				shift_r <= holdData_r;
				parBit_r <= parityOf(parityModeField, holdData_r, holdAddr_r); // [RQ2] [RQ4]
			end else if (bitTick && txState_r == uart_lce_pkg::TX_DATA) begin
				shift_r <= {1'b0, shift_r[7:1]};
			end
			if (txState_nxt != txState_r) begin
				bitCnt_r <= `COUNT_RESET;
			end else if (bitTick && bitCnt_r != 8'hff) begin
				bitCnt_r <= bitCnt_r + 8'h01;
			end
			if (txState_r != uart_lce_pkg::TX_BREAK) begin
				brkMinDone_r <= 1'b0;
			end else if (bitTick && bitCnt_r + 8'h01 >= charBits) begin
				brkMinDone_r <= 1'b1; // [RQ15]
			end
		end
	end

	// Transmit line level for the current state.
	always_ff @(posedge mclk) begin
		if (srst) begin
			txd <= 1'b1;
		end else begin
			unique case (txState_nxt)
				uart_lce_pkg::TX_START: txd <= 1'b0;
				uart_lce_pkg::TX_DATA: txd <= (bitTick && txState_r == uart_lce_pkg::TX_DATA) ?
					shift_r[1] : shift_r[0];
				uart_lce_pkg::TX_PARITY: txd <= parBit_r;
				uart_lce_pkg::TX_BREAK: txd <= 1'b0; // [RQ13]
				uart_lce_pkg::TX_IDLE, uart_lce_pkg::TX_STOP, uart_lce_pkg::TX_GUARD,
				uart_lce_pkg::TX_GAP: txd <= 1'b1; // [RQ6] [RQ19]
			endcase
		end
	end

	// Holding register and the address marker armed by the send-address command.
	always_ff @(posedge mclk) begin
		if (srst) begin
			holdData_r <= 8'h00;
			holdAddr_r <= 1'b0;
			holdFull_r <= 1'b0;
			addrPend_r <= 1'b0;
		end else begin
			if (holdAccept) begin
				holdData_r <= holdingData;
				holdAddr_r <= addrPend_r || sendAddressCmd; // [RQ4]
				holdFull_r <= 1'b1;
			end else if (launch) begin
				holdFull_r <= 1'b0; // [RQ7]
			end
			if (holdAccept) begin
				addrPend_r <= 1'b0;
			end else if (sendAddressCmd) begin
				addrPend_r <= 1'b1; // [RQ4]
			end
		end
	end

	// Break request and stop request bookkeeping.
	always_ff @(posedge mclk) begin
		if (srst) begin
			brkPend_r <= 1'b0;
			brkStopReq_r <= 1'b0;
		end else begin
			if (txState_nxt == uart_lce_pkg::TX_BREAK && txState_r != uart_lce_pkg::TX_BREAK) begin
				brkPend_r <= 1'b0;
			end else if (brkStartOk) begin
				brkPend_r <= 1'b1; // [RQ13] [RQ16]
			end
			if (txState_r != uart_lce_pkg::TX_BREAK) begin
				brkStopReq_r <= 1'b0; // [RQ18]
			end else if (brkStopOk) begin
				brkStopReq_r <= 1'b1;
			end
		end
	end

	// Received character classification.
	assign rxBreak = (rxCharData == 8'h00) && !rxStopBit &&
		(!hasParity(parityModeField) || !rxParityBit); // [RQ20]

	// Error flags: a setting event wins over a clear in the same cycle.
	always_ff @(posedge mclk) begin
		if (srst) begin
			parityErrorFlag <= 1'b0;
			framingErrorFlag <= 1'b0;
			breakSeenFlag <= 1'b0;
		end else begin
			if (rxCharDone && hasParity(parityModeField) && !rxBreak &&
					(multidrop ? rxParityBit :
					rxParityBit != parityOf(parityModeField, rxCharData, 1'b0))) begin
				parityErrorFlag <= 1'b1; // [RQ3]
			end else if (clearStatusCmd) begin
				parityErrorFlag <= 1'b0; // [RQ5]
			end
			if (rxCharDone && !rxStopBit && !rxBreak) begin
				framingErrorFlag <= 1'b1; // [RQ12]
			end else if (clearStatusCmd) begin
				framingErrorFlag <= 1'b0; // [RQ12]
			end
			if ((rxCharDone && rxBreak) || brkEnd) begin
				breakSeenFlag <= 1'b1; // [RQ20] [RQ21]
			end else if (clearStatusCmd) begin
				breakSeenFlag <= 1'b0; // [RQ20]
			end
		end
	end

	// End of a received break: enough consecutive high samples of the line.
	assign endSample = syncMode ? bitTick : sampleTick;
	assign brkEnd = rxInBreak_r && endSample && rxd &&
		(hiCnt_r + 2'h1 >= (syncMode ? `BRK_END_SYNC : `BRK_END_ASYNC)); // [RQ21]

	always_ff @(posedge mclk) begin
		if (srst) begin
			rxInBreak_r <= 1'b0;
			hiCnt_r <= 2'h0;
		end else begin
			if (rxCharDone && rxBreak) begin
				rxInBreak_r <= 1'b1;
			end else if (brkEnd) begin
				rxInBreak_r <= 1'b0;
			end
			if (!rxInBreak_r || (endSample && !rxd) || brkEnd) begin
				hiCnt_r <= 2'h0;
			end else if (endSample) begin
				hiCnt_r <= hiCnt_r + 2'h1;
			end
		end
	end

	// Receiver idle time-out counter.
	always_ff @(posedge mclk) begin
		if (srst) begin
			toCnt_r <= `TIMEOUT_RESET;
			toRun_r <= 1'b0;
			toWait_r <= 1'b0;
			timeoutFlag <= 1'b0;
		end else if (timeoutValueField == 16'h0000) begin
			toCnt_r <= `TIMEOUT_RESET;
			toRun_r <= 1'b0;
			toWait_r <= 1'b0;
			timeoutFlag <= 1'b0; // [RQ8]
		end else if (reloadTimeoutCmd) begin
			toCnt_r <= timeoutValueField;
			toRun_r <= 1'b1; // [RQ11]
			toWait_r <= 1'b0;
			timeoutFlag <= 1'b0; // [RQ25]
		end else if (armTimeoutCmd) begin
			toCnt_r <= timeoutValueField;
			toRun_r <= 1'b0; // [RQ10]
			toWait_r <= 1'b1;
			timeoutFlag <= 1'b0; // [RQ25]
		end else if (rxCharDone) begin
			toCnt_r <= timeoutValueField; // [RQ9]
			if (toWait_r || toRun_r) begin
				toRun_r <= 1'b1;
			end
			toWait_r <= 1'b0;
		end else if (toRun_r && bitTick) begin
			if (toCnt_r <= 16'h0001) begin
				toCnt_r <= `TIMEOUT_RESET;
				toRun_r <= 1'b0;
				timeoutFlag <= 1'b1; // [RQ9]
			end else begin
				toCnt_r <= toCnt_r - 16'h0001; // [RQ9]
			end
		end
	end

	// Request-to-send tells the remote side when reception is impossible.
	assign rts = handshake && ((!rxEnable && rxBufferFullStatus) || !fifoReady); // [RQ23]

	// Received characters wait in a small buffer until the consumer takes them.
	lce_fifo #(
		.WIDTH(8),
		.DEPTH(RX_FIFO_DEPTH)
	) rxFifo (
		.mclk(mclk),
		.srst(srst),
		.inValid(rxCharDone && rxEnable && !rxBreak),
		.inReady(fifoReady),
		.inData(rxCharData),
		.outValid(rxOutValid),
		.outReady(rxOutReady),
		.outData(rxOutData)
	);

	// Checks of the guarded behaviour.
	default clocking cb @(posedge mclk);
	endclocking
	default disable iff (srst);

	mdParity_a: assert property (rxCharDone && multidrop && rxParityBit && !rxBreak |=> // [RQ3]
		parityErrorFlag) else $error("multidrop address did not flag parity");
	addrParity_a: assert property (launch && multidrop |=> parBit_r == $past(holdAddr_r)) // [RQ2]
		else $error("multidrop parity does not follow address marker");
	guardZero_a: assert property (guardTimeField == 8'h00 && txState_r == uart_lce_pkg::TX_STOP // [RQ6]
		|=> txState_r != uart_lce_pkg::TX_GUARD) else $error("guard entered with zero guard");
	guardIdle_a: assert property (txState_r == uart_lce_pkg::TX_GUARD |-> !txIdleFlag) // [RQ7]
		else $error("idle flag high during guard time");
	toOff_a: assert property (timeoutValueField == 16'h0000 |=> !timeoutFlag) // [RQ8]
		else $error("time-out flag set while disabled");
	toFrozen_a: assert property (toWait_r && !rxCharDone && !reloadTimeoutCmd // [RQ10]
		&& !armTimeoutCmd |=> $stable(toCnt_r) && !timeoutFlag) else $error("armed counter moved");
	toReload_a: assert property (reloadTimeoutCmd && timeoutValueField != 16'h0000 |=> // [RQ11]
		toRun_r && toCnt_r == $past(timeoutValueField)) else $error("reload did not restart");
	frame_a: assert property (rxCharDone && !rxStopBit && !rxBreak |=> framingErrorFlag) // [RQ12]
		else $error("framing error missed");
	breakLow_a: assert property (txState_r == uart_lce_pkg::TX_BREAK |-> !txd) // [RQ13]
		else $error("line high during break");
	breakMin_a: assert property ($fell(txState_r == uart_lce_pkg::TX_BREAK) |-> // [RQ15]
		$past(bitCnt_r) + 8'h01 >= charBits) else $error("break shorter than minimum");
	breakGap_a: assert property ($fell(txState_r == uart_lce_pkg::TX_BREAK) |-> // [RQ19]
		(txState_r == uart_lce_pkg::TX_GAP && txd) [*2]) else $error("no idle gap after break");
	rxBreak_a: assert property (rxCharDone && rxBreak |=> breakSeenFlag && !$rose(framingErrorFlag)) // [RQ20]
		else $error("received break misreported");
	rtsHigh_a: assert property (handshake && !rxEnable && rxBufferFullStatus |-> rts) // [RQ23]
		else $error("request-to-send low while reception impossible");
	ctsHold_a: assert property (ctsBlock && txState_r == uart_lce_pkg::TX_IDLE && !brkPend_r // [RQ24]
		|=> txState_r != uart_lce_pkg::TX_START) else $error("character started while blocked");

	charSent_c: cover property (launch ##[1:200] txState_r == uart_lce_pkg::TX_STOP);
	breakDone_c: cover property (txState_r == uart_lce_pkg::TX_GAP ##1 txState_r == uart_lce_pkg::TX_IDLE);
	timeout_c: cover property ($rose(timeoutFlag));
	fifoFull_c: cover property (!fifoReady);

endmodule

// file: bench/remote_serial_dev.sv
// Behavioural remote serial device that decodes the transmit line and drives clear-to-send.
`timescale 1ns/100ps
module remote_serial_dev (
	// Clock and bit strobe.
	input wire logic mclk,
	input wire logic bitTick,
	// Line, frame format and hold-off request.
	input wire logic txd,
	input wire logic parityOn,
	input wire logic stall,
	// Handshake and decoded characters.
	output logic cts,
	output logic gotValid,
	output logic [7:0] gotData,
	output logic gotPar
);
	int pos_r = 0;
	logic armed_r = 1'b0;
	logic [8:0] bits_r = 9'h000;
	// A high clear-to-send holds the transmitter off between characters.
	assign cts = stall;
	// One sample per bit; a start needs a high sample first, so a long break is one frame.
	always @(posedge mclk) begin
		gotValid <= 1'b0;
		if (bitTick) begin
			if (pos_r == 0) begin
				armed_r <= txd;
				if (armed_r && !txd) begin
					pos_r <= 1;
				end
			end else if (pos_r <= 8 + int'(parityOn)) begin
				bits_r <= {txd, bits_r[8:1]};
				pos_r <= pos_r + 1;
			end else begin
				pos_r <= 0;
				armed_r <= txd;
				gotValid <= txd;
				gotData <= parityOn ? bits_r[7:0] : bits_r[8:1];
				gotPar <= parityOn & bits_r[8];
			end
		end
	end
endmodule

// file: bench/uart_line_control_extensions_test.sv
// Self-checking bench of the serial line-control extensions against a queue model.
`timescale 1ns/100ps
module uart_line_control_extensions_test;
	localparam int BIT = 32;
	localparam int TOUT = 0, IDLE = 1, FREE = 2, TXD = 3;
	logic mclk, srst, bitTick, sampleTick, syncMode, sendAddressCmd, clearStatusCmd;
	logic armTimeoutCmd, reloadTimeoutCmd, breakStartCmd, breakStopCmd, holdingWrite;
	logic rxCharDone, rxParityBit, rxStopBit, rxEnable, rxBufferFullStatus, rxOutReady, rxd;
	logic stall, txHoldingFreeFlag, txIdleFlag, parityErrorFlag, framingErrorFlag;
	logic breakSeenFlag, timeoutFlag, rxOutValid, txd, cts, rts, gotValid, gotPar;
	logic [2:0] parityModeField;
	logic [3:0] operatingModeField, obs;
	logic [7:0] guardTimeField, holdingData, rxCharData, rxOutData, gotData;
	logic [15:0] timeoutValueField;
	logic [8:0] txExp[$], lineSeen[$];
	logic [7:0] rxExp[$];
	int err_total = 0, n_tests = 0, tick = 0, n, g, m, hb;
	time tRise;
	string phase;

	uart_line_control_extensions #(.RX_FIFO_DEPTH(4)) i_uart_line_control_extensions (.mclk,
		.srst, .bitTick, .sampleTick, .parityModeField, .operatingModeField, .syncMode,
		.guardTimeField, .timeoutValueField, .sendAddressCmd, .clearStatusCmd, .armTimeoutCmd,
		.reloadTimeoutCmd, .breakStartCmd, .breakStopCmd, .holdingWrite, .holdingData,
		.txHoldingFreeFlag, .txIdleFlag, .parityErrorFlag, .framingErrorFlag, .breakSeenFlag,
		.timeoutFlag, .rxCharDone, .rxCharData, .rxParityBit, .rxStopBit, .rxEnable,
		.rxBufferFullStatus, .rxOutValid, .rxOutReady, .rxOutData, .txd, .rxd, .cts, .rts);
	remote_serial_dev i_remote_serial_dev (.mclk, .bitTick, .txd, .stall,
		.parityOn(parityModeField[2:1] != 2'h2), .cts, .gotValid, .gotData, .gotPar);
	assign obs = {txd, txHoldingFreeFlag, txIdleFlag, timeoutFlag};

	// Clock, then bit and oversample strobes; one bit period is BIT clocks.
	initial begin
		mclk = 1'b0;
		forever #4 mclk = ~mclk;
	end
	always @(posedge mclk) begin
		#1;
		tick = (tick + 1) % BIT;
		bitTick = (tick == 0);
		sampleTick = tick[0];
	end
	// Characters decoded by the remote device are queued for comparison.
	always @(posedge mclk) begin
		if (gotValid === 1'b1) lineSeen.push_back({gotPar, gotData});
	end

	task automatic check(input logic [15:0] seen, input logic [15:0] exp);
		n_tests++;
		if (seen !== exp) begin
			err_total++;
			$display("CHECK FAILED at %0t: %s seen %h expected %h", $time, phase, seen, exp);
		end
	endtask
	task automatic stop_test();
		$display("Checks %0d, mismatches %0d", n_tests, err_total);
		if (err_total == 0 && n_tests > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic cyc(input int k);
		repeat (k) @(posedge mclk);
		#1;
	endtask
	task automatic pulse(ref logic s);
		s = 1'b1;
		cyc(1);
		s = 1'b0;
		cyc(1);
	endtask
	// Waits up to lim clocks for a level; n returns the clocks spent.
	task automatic waitFor(input int idx, input logic v, input int lim);
		n = 0;
		while (obs[idx] !== v) begin
			n++;
			if (n > lim) begin
				check(16'h0000, 16'h0001);
				stop_test();
			end
			cyc(1);
		end
	endtask
	// Lines a command up with the edge that also carries a bit strobe.
	task automatic alignTick();
		@(posedge mclk iff tick == BIT - 1);
		#1;
	endtask
	task automatic sendChar(input logic [7:0] d, input logic addr);
		waitFor(FREE, 1'b1, 40 * BIT);
		sendAddressCmd = addr;
		holdingData = d;
		holdingWrite = 1'b1;
		cyc(1);
		{sendAddressCmd, holdingWrite} = 2'h0;
		cyc(1);
		txExp.push_back({addr, d});
	endtask
	task automatic rxChar(input logic [7:0] d, input logic p, input logic s);
		rxCharData = d;
		rxParityBit = p;
		rxStopBit = s;
		pulse(rxCharDone);
	endtask
	task automatic drainTx();
		waitFor(IDLE, 1'b1, 60 * BIT);
		cyc(BIT);
		check(16'(lineSeen.size()), 16'(txExp.size()));
		while (lineSeen.size() > 0 && txExp.size() > 0) begin
			check(lineSeen.pop_front(), txExp.pop_front());
		end
		lineSeen.delete();
		txExp.delete();
		$display("Test %s done, %0d mismatches so far", phase, err_total);
	endtask

	// Main sequence: reset, then one scenario group after another.
	initial begin
		{syncMode, sendAddressCmd, clearStatusCmd, armTimeoutCmd, reloadTimeoutCmd} = '0;
		{breakStartCmd, breakStopCmd, holdingWrite, rxCharDone, rxParityBit, rxStopBit} = '0;
		{rxEnable, rxBufferFullStatus, rxOutReady, stall, bitTick, sampleTick} = '0;
		{srst, rxd} = 2'h3;
		parityModeField = 3'h6;
		operatingModeField = 4'h0;
		guardTimeField = 8'h00;
		timeoutValueField = 16'h0000;
		holdingData = 8'h00;
		rxCharData = 8'h00;
		void'($urandom(72010));
		cyc(12);
		srst = 1'b0;
		phase = "reset";
		check({txd, txHoldingFreeFlag, txIdleFlag, parityErrorFlag, framingErrorFlag,
			breakSeenFlag, timeoutFlag, rxOutValid, rts}, 16'h01c0);
		phase = "multidrop";
		for (m = 6; m < 8; m++) begin
			parityModeField = 3'(m);
			sendChar(8'($urandom()), 1'b1);
			sendChar(8'($urandom()), 1'b0);
			drainTx();
			rxChar(8'($urandom()), 1'b1, 1'b1);
			check(parityErrorFlag, 1'b1);
			pulse(clearStatusCmd);
			check(parityErrorFlag, 1'b0);
			rxChar(8'($urandom()), 1'b0, 1'b1);
			check(parityErrorFlag, 1'b0);
		end
		phase = "rx break";
		rxChar(8'h55, 1'b0, 1'b0);
		check({framingErrorFlag, breakSeenFlag}, 2'h2);
		for (m = 0; m < 2; m++) begin
			syncMode = m[0];
			pulse(clearStatusCmd);
			check({framingErrorFlag, breakSeenFlag}, 2'h0);
			rxd = 1'b0;
			rxChar(8'h00, 1'b0, 1'b0);
			check({framingErrorFlag, breakSeenFlag}, 2'h1);
			pulse(clearStatusCmd);
			rxd = 1'b1;
			cyc(BIT + 2);
			check(breakSeenFlag, 1'b1);
		end
		phase = "timeguard";
		for (g = 0; g < 4; g += 3) begin
			guardTimeField = 8'(g);
			parityModeField = (g == 0) ? 3'h7 : 3'h4;
			sendChar(8'($urandom()), 1'b0);
			waitFor(TXD, 1'b0, 2 * BIT);
			sendChar(8'($urandom()), 1'b0);
			waitFor(FREE, 1'b1, 30 * BIT);
			check(16'((n + BIT / 2) / BIT), 16'(10 + g + int'(g == 0)));
			waitFor(IDLE, 1'b1, 30 * BIT);
			check(16'((n + BIT / 2) / BIT), 16'(10 + g + int'(g == 0)));
			drainTx();
		end
		phase = "timeout";
		parityModeField = 3'h7;
		timeoutValueField = 16'h0005;
		alignTick();
		pulse(reloadTimeoutCmd);
		waitFor(TOUT, 1'b1, 8 * BIT);
		check(16'((n + 2 + BIT / 2) / BIT), 16'h0005);
		cyc(3 * BIT);
		check(timeoutFlag, 1'b1);
		pulse(armTimeoutCmd);
		cyc(10 * BIT);
		check(timeoutFlag, 1'b0);
		rxChar(8'h11, 1'b0, 1'b1);
		cyc(3 * BIT);
		alignTick();
		rxChar(8'h22, 1'b0, 1'b1);
		waitFor(TOUT, 1'b1, 8 * BIT);
		check(16'((n + 2 + BIT / 2) / BIT), 16'h0005);
		timeoutValueField = 16'h0000;
		pulse(reloadTimeoutCmd);
		cyc(10 * BIT);
		check(timeoutFlag, 1'b0);
		phase = "tx break";
		for (g = 0; g < 16; g += 15) begin
			guardTimeField = 8'(g);
			pulse(breakStopCmd);
			cyc(2 * BIT);
			check({txd, txIdleFlag}, 2'h3);
			sendChar(8'($urandom()), 1'b0);
			waitFor(TXD, 1'b0, 2 * BIT);
			pulse(breakStartCmd); // Start and stop always go in separate writes.
			check({txHoldingFreeFlag, txIdleFlag}, 2'h0);
			holdingData = 8'h5a;
			pulse(holdingWrite);
			waitFor(FREE, 1'b1, (12 + g) * BIT);
			pulse(breakStartCmd);
			pulse(breakStopCmd);
			waitFor(TXD, 1'b1, 30 * BIT);
			check(16'((n + 4 + BIT / 2) / BIT), 16'h000b);
			tRise = $time;
			sendChar(8'($urandom()), 1'b0);
			waitFor(TXD, 1'b0, 2 * BIT);
			hb = int'(($time - tRise) / (8 * BIT));
			m = g > 12 ? g : 12;
			check(hb >= m && hb <= m + 1, 1'b1);
			drainTx();
		end
		phase = "handshake";
		rxBufferFullStatus = 1'b1;
		cyc(1);
		check(rts, 1'b0);
		operatingModeField = 4'h2;
		cyc(1);
		check(rts, 1'b1);
		rxEnable = 1'b1;
		cyc(1);
		check(rts, 1'b0);
		rxBufferFullStatus = 1'b0;
		sendChar(8'($urandom()), 1'b0);
		waitFor(TXD, 1'b0, 2 * BIT);
		stall = 1'b1;
		sendChar(8'($urandom()), 1'b0);
		cyc(20 * BIT);
		check(16'(lineSeen.size()), 16'h0001);
		stall = 1'b0;
		drainTx();
		phase = "rx fifo";
		for (m = 0; m < 5; m++) begin
			g = $urandom();
			rxChar(8'(g), 1'b0, 1'b1);
			if (m < 4) rxExp.push_back(8'(g));
		end
		check({rxOutValid, rts}, 2'h3);
		rxOutReady = 1'b1;
		for (m = 0; m < 4; m++) begin
			check(rxOutData, rxExp.pop_front());
			cyc(1);
		end
		rxOutReady = 1'b0;
		check({rxOutValid, rts}, 2'h0);
		$display("Test %s done, %0d mismatches so far", phase, err_total);
		stop_test();
	end
endmodule
